/* File: inc/ecce_mul_if.sv */
`timescale 1ns/1ns
interface ecce_mul_if;
   import ecce_pkg::*;
   logic [BLK_W-1:0]   a;
   logic [BLK_W-1:0]   b;
   logic               field;
   wire  [2*BLK_W-1:0] p;
   modport seq (output a, output b, output field, input p);
   modport pe (input a, input b, input field, output p);
endinterface

/* File: inc/ecce_pkg.sv */
package ecce_pkg;

   // Storage geometry: 3 kB microcode and 2 kB scratch, both as 32-bit words.
   localparam int UCODE_DEPTH = 768;
   localparam int UCODE_AW    = 10;
   localparam int SCR_DEPTH   = 512;
   localparam int SCR_AW      = 9;

   // Shared window in data RAM: 1 kB pages, 32-byte operand slots.
   localparam int DADDR_W     = 17;
   localparam int PAGE_W      = 7;
   localparam int PAGE_SHIFT  = 10;
   localparam int SLOT_W      = 6;
   localparam int SLOT_SHIFT  = 5;
   localparam int WORD_SHIFT  = 2;

   // Command entry points are spaced evenly through the microcode.
   localparam int ENTRY_SHIFT = 6;

   // Arithmetic: four 16x16 lanes over one 64-bit block.
   localparam int LANES  = 4;
   localparam int LANE_W = 16;
   localparam int BLK_W  = 64;

   // Fixed slots of the signing layout.
   localparam logic [SLOT_W-1:0] SLOT_MODULUS = 6'h00;
   localparam logic [SLOT_W-1:0] SLOT_ORDER   = 6'h01;
   localparam logic [SLOT_W-1:0] SLOT_GEN_X   = 6'h02;
   localparam logic [SLOT_W-1:0] SLOT_GEN_Y   = 6'h03;
   localparam logic [SLOT_W-1:0] SLOT_COEF_A  = 6'h04;
   localparam logic [SLOT_W-1:0] SLOT_COEF_B  = 6'h05;
   localparam logic [SLOT_W-1:0] SLOT_PRIVKEY = 6'h06;
   localparam logic [SLOT_W-1:0] SLOT_NONCE   = 6'h07;
   localparam logic [SLOT_W-1:0] SLOT_SIG_R   = 6'h0A;
   localparam logic [SLOT_W-1:0] SLOT_SIG_S   = 6'h0B;
   localparam logic [SLOT_W-1:0] SLOT_DIGEST  = 6'h0C;

   // Throughput figures the microcode and datapath are sized for.
   localparam int CLK_PERIOD_NS     = 10;
   localparam int TARGET_MULS_PER_S = 90;
   localparam int TARGET_CLK_MHZ    = 96;
   localparam int AVG_CURVE_CYCLES  = 100000;

   typedef enum logic [1:0] {
      SIZE_64  = 2'b00,
      SIZE_128 = 2'b01,
      SIZE_256 = 2'b10
   } ecce_size_t;

   typedef enum logic [2:0] {
      CMD_POINT_MUL          = 3'b000,
      CMD_MODULAR_REDUCE     = 3'b001,
      CMD_MODULAR_INVERSE    = 3'b010,
      CMD_MODULAR_MULTIPLY   = 3'b011,
      CMD_MODULAR_ADD        = 3'b100,
      CMD_USER5              = 3'b101,
      CMD_USER6              = 3'b110,
      CMD_USER7              = 3'b111
   } ecce_cmd_t;

   typedef enum logic [3:0] {
      OP_NOP   = 4'h0,
      OP_LOAD  = 4'h1,
      OP_STORE = 4'h2,
      OP_ADD   = 4'h3,
      OP_MUL   = 4'h4,
      OP_END   = 4'hF
   } ecce_op_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_FETCH  = 3'b001,
      ST_DECODE = 3'b010,
      ST_MEMRD  = 3'b011,
      ST_MEMWR  = 3'b100,
      ST_ALU    = 3'b101,
      ST_MULW   = 3'b110,
      ST_DONE   = 3'b111
   } ecce_state_t;

   // Microinstruction; for LOAD and STORE srca is {mode, slot}.
   typedef struct packed {
      ecce_op_t   op;
      logic       field;
      logic [8:0] dst;
      logic [8:0] srca;
      logic [8:0] srcb;
   } ecce_instr_t;

   typedef struct packed {
      ecce_state_t         state;
      logic [UCODE_AW-1:0] pc;
      ecce_instr_t         ir;
      logic [2:0]          cnt;
      logic                carry;
      logic                busy;
      logic                irq;
      logic                ucode_ok;
      logic                req;
      logic                we;
      logic [DADDR_W-1:0]  addr;
      logic [31:0]         wdata;
   } ecce_seq_t;

   typedef struct packed {
      logic [2*LANE_W-1:0] prod;
   } ecce_pe_t;

   localparam ecce_seq_t SEQ_RST = ecce_seq_t'(0);
   localparam ecce_pe_t  PE_RST  = ecce_pe_t'(0);

endpackage

/* File: logic/ecce_dual_field_element.sv */
`timescale 1ns/1ns
module ecce_dual_field_element #(
   parameter int LANE = 0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Operand lanes and products
   ecce_mul_if.pe   mul
);
   import ecce_pkg::*;

   ecce_pe_t            s_reg;
   ecce_pe_t            s_next;
   logic [LANE_W-1:0]   a;
   logic [LANE_W-1:0]   b;
   logic [2*LANE_W-1:0] clmul;

   assign a = mul.a[LANE*LANE_W +: LANE_W];
   assign b = mul.b[LANE*LANE_W +: LANE_W];

   // Integer product for prime fields, carry-less product for binary fields.
   always_comb begin
      clmul = '0;
      for (int i = 0; i < LANE_W; i++) begin
         if (b[i]) begin
            clmul = clmul ^ ((2*LANE_W)'(a) << i);
         end
      end
      s_next.prod = mul.field ? clmul : (2*LANE_W)'(a) * (2*LANE_W)'(b);
   end

   // One register stage; the sequencer reads the product one cycle later.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_reg <= PE_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign mul.p[LANE*2*LANE_W +: 2*LANE_W] = s_reg.prod;

endmodule

/* File: logic/ecce_engine.sv */
`timescale 1ns/1ns
module ecce_engine (
   // Clock and reset
   input  wire logic                          CORE_CLK,
   input  wire logic                          RST,
   // Command and configuration
   input  wire logic                          START,
   input  wire ecce_pkg::ecce_cmd_t           CMD,
   input  wire ecce_pkg::ecce_size_t          OP_SIZE,
   input  wire logic [ecce_pkg::PAGE_W-1:0]   WINDOW_PAGE,
   input  wire logic [ecce_pkg::SLOT_W-1:0]   OPERAND_POINTER_A,
   input  wire logic [ecce_pkg::SLOT_W-1:0]   OPERAND_POINTER_B,
   input  wire logic [ecce_pkg::SLOT_W-1:0]   OPERAND_POINTER_C,
   input  wire logic                          IRQ_ENABLE,
   input  wire logic                          ENGINE_CLK_EN,
   // Power control
   input  wire logic                          SLEEP,
   input  wire logic                          MICROCODE_RAM_RETAIN,
   // Microcode load port
   input  wire logic                          UCODE_WE,
   input  wire logic [ecce_pkg::UCODE_AW-1:0] UCODE_ADDR,
   input  wire logic [31:0]                   UCODE_WDATA,
   // Status
   output wire logic                          BUSY,
   output wire logic                          UCODE_READY,
   output wire logic                          IRQ,
   // Data RAM port
   output wire logic                          MEM_REQ,
   output wire logic                          MEM_WE,
   output wire logic [ecce_pkg::DADDR_W-1:0]  MEM_ADDR,
   output wire logic [31:0]                   MEM_WDATA,
   input  wire logic                          MEM_ACK,
   input  wire logic [31:0]                   MEM_RDATA
);
   import ecce_pkg::*;

   ecce_seq_t          s_reg;
   ecce_seq_t          s_next;
   ecce_instr_t        ir;
   logic [31:0]        ucode_mem [UCODE_DEPTH];
   logic [31:0]        scr_mem [SCR_DEPTH];
   logic [3:0]         wr_en;
   logic [SCR_AW-1:0]  wr_addr;
   logic [127:0]       wr_data;
   logic [3:0]         nwords;
   logic [2:0]         last_word;
   logic [2:0]         last_blk;
   logic [SLOT_W-1:0]  slot;
   logic [SCR_AW-1:0]  rd_a;
   logic [SCR_AW-1:0]  rd_b;
   logic [BLK_W-1:0]   opa;
   logic [BLK_W-1:0]   opb;
   logic [BLK_W:0]     sum;

   ecce_mul_if mul_bus ();

   // Byte address of word c of a slot in the shared window.
   function automatic logic [DADDR_W-1:0] win_addr(input logic [PAGE_W-1:0] page,
                                                  input logic [SLOT_W-1:0] sl,
                                                  input logic [2:0]        c);
      win_addr = (DADDR_W'(page) << PAGE_SHIFT)
               + (DADDR_W'(sl) << SLOT_SHIFT)
               + (DADDR_W'(c) << WORD_SHIFT);
   endfunction

   // Operand length in words; widths above 256 bits cannot be configured.
   always_comb begin
      case (OP_SIZE)
         SIZE_64:  nwords = 4'h2;
         SIZE_128: nwords = 4'h4;
         SIZE_256: nwords = 4'h8;
         default:  nwords = 4'h8;
      endcase
      last_word = 3'(nwords - 4'h1);
      last_blk  = 3'((nwords >> 1) - 4'h1);
   end

   // Window slots are fixed by number or taken from one of the pointers.
   always_comb begin
      ir = s_reg.ir;
      case (ir.srca[8:6])
         3'h0:    slot = ir.srca[5:0];
         3'h1:    slot = OPERAND_POINTER_A;
         3'h2:    slot = OPERAND_POINTER_B;
         default: slot = OPERAND_POINTER_C;
      endcase
      rd_a = SCR_AW'(ir.srca + 9'({s_reg.cnt, 1'b0}));
      rd_b = SCR_AW'(ir.srcb + 9'({s_reg.cnt, 1'b0}));
      opa  = {scr_mem[SCR_AW'(rd_a + 9'h001)], scr_mem[rd_a]};
      opb  = {scr_mem[SCR_AW'(rd_b + 9'h001)], scr_mem[rd_b]};
   end

   assign mul_bus.a     = opa;
   assign mul_bus.b     = opb;
   assign mul_bus.field = ir.field;

   for (genvar g = 0; g < LANES; g++) begin : g_lane
      ecce_dual_field_element #(
         .LANE (g)
      ) u_pe (
         .clk (CORE_CLK),
         .rst (RST),
         .mul (mul_bus.pe)
      );
   end

   always_comb begin
      s_next     = s_reg;
      s_next.irq = 1'b0;
      wr_en      = 4'h0;
      wr_addr    = '0;
      wr_data    = '0;
      sum        = '0;
      // Losing power without retention invalidates the microcode; a fresh load wins.
      if (SLEEP && !MICROCODE_RAM_RETAIN) begin
         s_next.ucode_ok = 1'b0;
      end
      if (UCODE_WE && !s_reg.busy) begin
         s_next.ucode_ok = 1'b1;
      end
      // A gated engine holds its sequencer state; IRQ still clears and UCODE_READY still follows SLEEP and microcode loads.
      if (ENGINE_CLK_EN) begin
         case (s_reg.state)
            ST_IDLE: begin
               if (START && s_reg.ucode_ok) begin
                  s_next.pc    = UCODE_AW'(CMD) << ENTRY_SHIFT;
                  s_next.busy  = 1'b1;
                  s_next.state = ST_FETCH;
               end
            end
            ST_FETCH: begin
               s_next.ir    = ecce_instr_t'(ucode_mem[s_reg.pc]);
               s_next.pc    = s_reg.pc + 10'h001;
               s_next.cnt   = 3'h0;
               s_next.carry = 1'b0;
               s_next.state = ST_DECODE;
            end
            ST_DECODE: begin
               case (ir.op)
                  OP_LOAD: begin
                     s_next.req   = 1'b1;
                     s_next.we    = 1'b0;
                     s_next.addr  = win_addr(WINDOW_PAGE, slot, 3'h0);
                     s_next.state = ST_MEMRD;
                  end
                  OP_STORE: begin
                     s_next.req   = 1'b1;
                     s_next.we    = 1'b1;
                     s_next.addr  = win_addr(WINDOW_PAGE, slot, 3'h0);
                     s_next.wdata = scr_mem[SCR_AW'(ir.srcb)];
                     s_next.state = ST_MEMWR;
                  end
                  OP_ADD:  s_next.state = ST_ALU;
                  OP_MUL:  s_next.state = ST_ALU;
                  OP_END:  s_next.state = ST_DONE;
                  default: s_next.state = ST_FETCH;
               endcase
            end
            ST_MEMRD: begin
               if (MEM_ACK) begin
                  wr_en[0]     = 1'b1;
                  wr_addr      = SCR_AW'(ir.dst + 9'(s_reg.cnt));
                  wr_data      = 128'(MEM_RDATA);
                  s_next.cnt   = s_reg.cnt + 3'h1;
                  s_next.addr  = win_addr(WINDOW_PAGE, slot, s_reg.cnt + 3'h1);
                  if (s_reg.cnt == last_word) begin
                     s_next.req   = 1'b0;
                     s_next.state = ST_FETCH;
                  end
               end
            end
            ST_MEMWR: begin
               if (MEM_ACK) begin
                  s_next.cnt   = s_reg.cnt + 3'h1;
                  s_next.addr  = win_addr(WINDOW_PAGE, slot, s_reg.cnt + 3'h1);
                  s_next.wdata = scr_mem[SCR_AW'(ir.srcb + 9'(s_reg.cnt + 3'h1))];
                  if (s_reg.cnt == last_word) begin
                     s_next.req   = 1'b0;
                     s_next.we    = 1'b0;
                     s_next.state = ST_FETCH;
                  end
               end
            end
            ST_ALU: begin
               if (ir.op == OP_MUL) begin
                  s_next.state = ST_MULW;
               end else begin
                  // Binary-field add is carry-free; prime-field add chains its carry.
                  sum = ir.field ? {1'b0, opa ^ opb}
                                 : {1'b0, opa} + {1'b0, opb} + (BLK_W+1)'(s_reg.carry);
                  wr_en        = 4'h3;
                  wr_addr      = SCR_AW'(ir.dst + 9'({s_reg.cnt, 1'b0}));
                  wr_data      = 128'(sum[BLK_W-1:0]);
                  s_next.carry = sum[BLK_W];
                  s_next.cnt   = s_reg.cnt + 3'h1;
                  if (s_reg.cnt == last_blk) begin
                     s_next.state = ST_FETCH;
                  end
               end
            end
            ST_MULW: begin
               wr_en      = 4'hF;
               wr_addr    = SCR_AW'(ir.dst + 9'({s_reg.cnt, 2'b00}));
               wr_data    = mul_bus.p;
               s_next.cnt = s_reg.cnt + 3'h1;
               s_next.state = (s_reg.cnt == last_blk) ? ST_FETCH : ST_ALU;
            end
            ST_DONE: begin
               // Every store has been acknowledged before END is reached.
               s_next.busy  = 1'b0;
               s_next.irq   = IRQ_ENABLE;
               s_next.state = ST_IDLE;
            end
            default: s_next.state = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         s_reg <= SEQ_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // Memories carry no reset; reset still clears UCODE_READY, so commands wait for a new microcode load.
   always_ff @(posedge CORE_CLK) begin
      if (UCODE_WE && !s_reg.busy) begin
         ucode_mem[UCODE_ADDR] <= UCODE_WDATA;
      end
      for (int i = 0; i < 4; i++) begin
         if (wr_en[i]) begin
            scr_mem[SCR_AW'(wr_addr + SCR_AW'(i))] <= wr_data[32*i +: 32];
         end
      end
   end

   assign BUSY        = s_reg.busy;
   assign UCODE_READY = s_reg.ucode_ok;
   assign IRQ         = s_reg.irq;
   assign MEM_REQ     = s_reg.req;
   assign MEM_WE      = s_reg.we;
   assign MEM_ADDR    = s_reg.addr;
   assign MEM_WDATA   = s_reg.wdata;

endmodule

/* File: sim/ecce_engine_asserts.sv */
`timescale 1ns/1ns
module ecce_engine_asserts (
   // Clock and reset
   input wire logic                          CORE_CLK,
   input wire logic                          RST,
   // Control
   input wire logic                          START,
   input wire logic                          ENGINE_CLK_EN,
   input wire logic                          IRQ_ENABLE,
   input wire logic                          SLEEP,
   input wire logic                          MICROCODE_RAM_RETAIN,
   input wire logic                          UCODE_WE,
   // Status
   input wire logic                          BUSY,
   input wire logic                          UCODE_READY,
   input wire logic                          IRQ,
   // Data RAM port
   input wire logic                          MEM_REQ,
   input wire logic                          MEM_WE,
   input wire logic [ecce_pkg::DADDR_W-1:0]  MEM_ADDR,
   input wire logic [31:0]                   MEM_WDATA,
   input wire logic                          MEM_ACK
);
   import ecce_pkg::*;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   sequence s_accept;
      !BUSY && START && UCODE_READY && ENGINE_CLK_EN;
   endsequence
   sequence s_word_done;
      MEM_REQ && MEM_ACK;
   endsequence
   busy_start_a: assert property (s_accept |=> BUSY) else $error("Busy missing after start.");
   no_ucode_a: assert property (!BUSY && !UCODE_READY |=> !BUSY) else $error("Start taken without code.");
   clk_off_a: assert property (!BUSY && !ENGINE_CLK_EN |=> !BUSY) else $error("Start taken clock off.");
   irq_fall_a: assert property ($fell(BUSY) && IRQ_ENABLE && $past(IRQ_ENABLE) |-> IRQ)
      else $error("Interrupt missing at completion.");
   irq_cause_a: assert property (IRQ |-> $fell(BUSY)) else $error("Interrupt without completion.");
   irq_pulse_a: assert property (IRQ |=> !IRQ) else $error("Interrupt longer than one cycle.");
   req_hold_a: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE)
      && $stable(MEM_WDATA)) else $error("Memory request changed before ack.");
   addr_step_a: assert property (s_word_done ##1 MEM_REQ |-> MEM_ADDR == $past(MEM_ADDR) + 17'h00004)
      else $error("Operand words not ascending.");
   req_busy_a: assert property (MEM_REQ |-> BUSY) else $error("Memory traffic while idle.");
   retain_keep_a: assert property (SLEEP && MICROCODE_RAM_RETAIN && UCODE_READY |=> UCODE_READY)
      else $error("Code lost despite retention.");
   retain_lose_a: assert property (SLEEP && !MICROCODE_RAM_RETAIN && !UCODE_WE |=> !UCODE_READY)
      else $error("Code kept without retention.");
endmodule
bind ecce_engine ecce_engine_asserts u_asserts (
   .CORE_CLK(CORE_CLK), .RST(RST), .START(START), .ENGINE_CLK_EN(ENGINE_CLK_EN), .IRQ_ENABLE(IRQ_ENABLE),
   .SLEEP(SLEEP), .MICROCODE_RAM_RETAIN(MICROCODE_RAM_RETAIN), .UCODE_WE(UCODE_WE), .BUSY(BUSY),
   .UCODE_READY(UCODE_READY), .IRQ(IRQ), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
   .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK));

/* File: sim/ecce_ram_model.sv */
`timescale 1ns/1ns
module ecce_ram_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Request side
   input  wire logic        req,
   input  wire logic        we,
   input  wire logic [16:0] addr,
   input  wire logic [31:0] wdata,
   input  wire logic [1:0]  dly,
   // Answer side
   output logic             ack,
   output logic [31:0]      rdata
);
   logic [31:0] mem [int];
   logic [1:0]  wait_cnt;
   // Unwritten words in a slot's lower 16 bytes read as an address-derived pattern, so each byte lane is traceable.
   // Software keeps 128-bit values zero-padded to 256 bits, so a slot's upper half reads as zero.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ack <= 1'b0;
         rdata <= 32'h00000000;
         wait_cnt <= 2'h0;
      end else if (req && !ack && wait_cnt >= dly) begin
         ack <= 1'b1;
         wait_cnt <= 2'h0;
         if (we) begin
            mem[addr] = wdata;
            rdata <= ~rdata;
         end else begin
            rdata <= mem.exists(addr) ? mem[addr] : (addr[4] ? 32'h00000000 : {8'hA5, 7'h00, addr});
         end
      end else begin
         ack <= 1'b0;
         rdata <= ~rdata;
         if (req && !ack) begin
            wait_cnt <= wait_cnt + 2'h1;
         end
      end
   end
endmodule

/* File: sim/test_ecce_engine.sv */
`timescale 1ns/1ns
module test_ecce_engine;
   import ecce_pkg::*;
   logic                CORE_CLK, RST, START, IRQ_ENABLE, ENGINE_CLK_EN, SLEEP, MICROCODE_RAM_RETAIN, UCODE_WE;
   ecce_cmd_t           CMD;
   ecce_size_t          OP_SIZE;
   logic [PAGE_W-1:0]   WINDOW_PAGE;
   logic [SLOT_W-1:0]   OPERAND_POINTER_A, OPERAND_POINTER_B, OPERAND_POINTER_C;
   logic [UCODE_AW-1:0] UCODE_ADDR;
   logic [31:0]         UCODE_WDATA, MEM_WDATA, MEM_RDATA;
   logic                BUSY, UCODE_READY, IRQ, MEM_REQ, MEM_WE, MEM_ACK;
   logic [DADDR_W-1:0]  MEM_ADDR;
   logic [1:0]          ram_dly;
   logic                zero_res;
   logic [49:0]         log_q[$];
   int                  fails, checks, cycles;

   ecce_engine u_dut (.CORE_CLK(CORE_CLK), .RST(RST), .START(START), .CMD(CMD), .OP_SIZE(OP_SIZE),
      .WINDOW_PAGE(WINDOW_PAGE), .OPERAND_POINTER_A(OPERAND_POINTER_A), .OPERAND_POINTER_B(OPERAND_POINTER_B),
      .OPERAND_POINTER_C(OPERAND_POINTER_C), .IRQ_ENABLE(IRQ_ENABLE), .ENGINE_CLK_EN(ENGINE_CLK_EN),
      .SLEEP(SLEEP), .MICROCODE_RAM_RETAIN(MICROCODE_RAM_RETAIN), .UCODE_WE(UCODE_WE), .UCODE_ADDR(UCODE_ADDR),
      .UCODE_WDATA(UCODE_WDATA), .BUSY(BUSY), .UCODE_READY(UCODE_READY), .IRQ(IRQ), .MEM_REQ(MEM_REQ),
      .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA));
   ecce_ram_model u_ram (.clk(CORE_CLK), .rst(RST), .req(MEM_REQ), .we(MEM_WE), .addr(MEM_ADDR),
      .wdata(MEM_WDATA), .dly(ram_dly), .ack(MEM_ACK), .rdata(MEM_RDATA));

   initial begin
      CORE_CLK = 1'b0;
      forever #5 CORE_CLK = ~CORE_CLK;
   end

   // Every completed word is logged so transfers can be judged after the command.
   always @(posedge CORE_CLK) begin
      cycles++;
      if (MEM_REQ === 1'b1 && MEM_ACK === 1'b1) begin
         log_q.push_back({MEM_WE, MEM_ADDR, MEM_WE ? MEM_WDATA : MEM_RDATA});
      end
      if (cycles == 20000) begin
         fails++;
         results();
      end
   end

   task check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task results;
      $display("Checks %0d, failures %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task load_word(input int a, input logic [31:0] d);
      @(posedge CORE_CLK);
      UCODE_WE <= 1'b1;
      UCODE_ADDR <= a[UCODE_AW-1:0];
      UCODE_WDATA <= d;
      @(posedge CORE_CLK);
      UCODE_WE <= 1'b0;
   endtask

   task run_cmd(input ecce_cmd_t c, input logic exp_irq);
      int n;
      @(posedge CORE_CLK);
      CMD <= c;
      START <= 1'b1;
      @(posedge CORE_CLK);
      START <= 1'b0;
      #1 check(32'(BUSY), 32'h1);
      n = 0;
      while (BUSY === 1'b1 && n < 2000) begin
         @(posedge CORE_CLK);
         #1 n++;
      end
      check(32'(BUSY), 32'h0);
      check(32'(IRQ), 32'(exp_irq));
   endtask

   task expect_refused;
      @(posedge CORE_CLK);
      START <= 1'b1;
      repeat (3) @(posedge CORE_CLK);
      START <= 1'b0;
      #1 check(32'(BUSY), 32'h0);
   endtask

   // A copy from the digest slot to pointer A, then judged word by word.
   task t_copy(input ecce_size_t sz, input int words, input logic [5:0] ptr, input logic [6:0] page,
               input logic [1:0] dly);
      logic [16:0] ra;
      logic [16:0] wa;
      logic [49:0] e;
      logic [31:0] rd;
      @(posedge CORE_CLK);
      OP_SIZE <= sz;
      OPERAND_POINTER_A <= ptr;
      WINDOW_PAGE <= page;
      ram_dly <= dly;
      log_q.delete();
      run_cmd(CMD_MODULAR_ADD, 1'b1);
      check(32'(log_q.size()), 32'(2 * words));
      if (log_q.size() == 2 * words) begin
         for (int i = 0; i < words; i++) begin
            ra = {page, 10'h000} + 17'(32 * SLOT_DIGEST + 4 * i);
            wa = {page, 10'h000} + 17'(32 * ptr + 4 * i);
            rd = ra[4] ? 32'h00000000 : {8'hA5, 7'h00, ra};
            e = log_q[i];
            check(32'(e[49:32]), 32'(ra));
            check(e[31:0], rd);
            e = log_q[words + i];
            check(32'(e[49:32]), 32'({1'b1, wa}));
            check(e[31:0], rd);
         end
      end
   endtask

   // Operands through pointers A and B, one 128-bit operation, the result stored through pointer C.
   task t_arith(input logic [3:0] op, input logic fld, input logic [5:0] pb, input logic [5:0] pc,
                output logic z);
      logic [127:0] a;
      logic [127:0] b;
      logic [127:0] e;
      logic [31:0]  p;
      logic [49:0]  d;
      load_word(192, {4'h1, 1'b0, 9'h010, 9'h040, 9'h000});
      load_word(193, {4'h1, 1'b0, 9'h020, 9'h080, 9'h000});
      load_word(194, {op, fld, 9'h040, 9'h010, 9'h020});
      load_word(195, {4'h2, 1'b0, 9'h000, 9'h0C0, 9'h040});
      load_word(196, 32'hF0000000);
      for (int i = 0; i < 4; i++) begin
         a[32*i +: 32] = {8'hA5, 7'h00, 17'(2048 + 32 + 4 * i)};
         b[32*i +: 32] = {8'hA5, 7'h00, 17'(2048 + 32 * pb + 4 * i)};
      end
      // Lane products by shift and add, or by shift and exclusive-or for binary fields.
      e = (op == 4'h4) ? '0 : (fld ? a ^ b : a + b);
      for (int j = 0; j < 4; j++) begin
         for (int k = 0; k < 16; k++) begin
            if (op == 4'h4 && b[16*j+k]) begin
               p = 32'(a[16*j +: 16]) << k;
               e[32*j +: 32] = fld ? e[32*j +: 32] ^ p : e[32*j +: 32] + p;
            end
         end
      end
      @(posedge CORE_CLK);
      OP_SIZE <= SIZE_128;
      WINDOW_PAGE <= 7'h02;
      OPERAND_POINTER_A <= 6'h01;
      OPERAND_POINTER_B <= pb;
      OPERAND_POINTER_C <= pc;
      log_q.delete();
      run_cmd(CMD_MODULAR_MULTIPLY, 1'b1);
      check(32'(log_q.size()), 32'h0000000C);
      z = 1'b1;
      if (log_q.size() == 12) begin
         for (int i = 0; i < 4; i++) begin
            d = log_q[8 + i];
            check(32'(d[49:32]), 32'({1'b1, 17'(2048 + 32 * pc + 4 * i)}));
            check(d[31:0], e[32*i +: 32]);
            z = z & (d[31:0] == 32'h00000000);
         end
      end
   endtask

   initial begin
      {START, SLEEP, MICROCODE_RAM_RETAIN, UCODE_WE, UCODE_ADDR, UCODE_WDATA, ram_dly} = '0;
      {WINDOW_PAGE, OPERAND_POINTER_A, OPERAND_POINTER_B, OPERAND_POINTER_C} = '0;
      CMD = CMD_POINT_MUL;
      OP_SIZE = SIZE_64;
      IRQ_ENABLE = 1'b1;
      ENGINE_CLK_EN = 1'b1;
      RST = 1'b1;
      repeat (10) @(posedge CORE_CLK);
      RST <= 1'b0;
      #1 check(32'({BUSY, UCODE_READY, IRQ, MEM_REQ}), 32'h0);
      expect_refused();
      for (int c = 0; c < 8; c++) begin
         load_word(c * 64, 32'hF0000000);
      end
      load_word(256, 32'h10000000 | (32'(SLOT_DIGEST) << 9));
      load_word(257, 32'h20008000);
      load_word(258, 32'hF0000000);
      #1 check(32'(UCODE_READY), 32'h1);
      for (int c = 0; c < 8; c++) begin
         if (c != 4) begin
            run_cmd(ecce_cmd_t'(c), 1'b1);
         end
      end
      t_copy(SIZE_64, 2, 6'h0D, 7'h05, 2'h0);
      t_copy(SIZE_256, 8, 6'h1F, 7'h7F, 2'h3);
      t_copy(SIZE_128, 4, 6'h10, 7'h00, 2'h1);
      t_arith(4'h3, 1'b1, 6'h01, SLOT_SIG_R, zero_res);
      if (zero_res) begin
         t_arith(4'h3, 1'b1, SLOT_NONCE, SLOT_SIG_R, zero_res);
      end
      check(32'(zero_res), 32'h0);
      t_arith(4'h3, 1'b0, 6'h02, SLOT_SIG_S, zero_res);
      t_arith(4'h4, 1'b0, 6'h02, SLOT_SIG_S, zero_res);
      t_arith(4'h4, 1'b1, 6'h02, SLOT_SIG_S, zero_res);
      if (zero_res) begin
         t_arith(4'h4, 1'b1, SLOT_NONCE, SLOT_SIG_S, zero_res);
      end
      check(32'(zero_res), 32'h0);
      @(posedge CORE_CLK);
      ENGINE_CLK_EN <= 1'b0;
      expect_refused();
      @(posedge CORE_CLK);
      ENGINE_CLK_EN <= 1'b1;
      IRQ_ENABLE <= 1'b0;
      run_cmd(CMD_MODULAR_REDUCE, 1'b0);
      @(posedge CORE_CLK);
      SLEEP <= 1'b1;
      MICROCODE_RAM_RETAIN <= 1'b1;
      @(posedge CORE_CLK);
      SLEEP <= 1'b0;
      #1 check(32'(UCODE_READY), 32'h1);
      @(posedge CORE_CLK);
      SLEEP <= 1'b1;
      MICROCODE_RAM_RETAIN <= 1'b0;
      @(posedge CORE_CLK);
      SLEEP <= 1'b0;
      #1 check(32'(UCODE_READY), 32'h0);
      expect_refused();
      IRQ_ENABLE <= 1'b1;
      load_word(0, 32'hF0000000);
      run_cmd(CMD_POINT_MUL, 1'b1);
      results();
   end
endmodule
